// File: core/hmvwf_pkg.sv
// Shared constants for the host MAC tag and wake-up filter block.
package hmvwf_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] IDX_FIRST_TAG = 8'h09;
  localparam logic [ADDR_W-1:0] IDX_SECOND_TAG = 8'h0a;
  localparam logic [ADDR_W-1:0] IDX_WAKE_FILTER = 8'h0b;
  localparam logic [ADDR_W-1:0] IDX_WAKE_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h0d;
  localparam logic [ADDR_W-1:0] ADDR_FIRST_TAG = IDX_FIRST_TAG << 2;
  localparam logic [ADDR_W-1:0] ADDR_SECOND_TAG = IDX_SECOND_TAG << 2;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_FILTER = IDX_WAKE_FILTER << 2;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_CTRL = IDX_WAKE_CTRL << 2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = IDX_IRQ_MASK << 2;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int unsigned TAG_W = 16;
  localparam logic [TAG_W-1:0] TAG_RESET = 16'hffff;
  localparam int unsigned BIT_GLOBAL_UNICAST_EN = 9;
  localparam int unsigned BIT_WAKE_FRAME_RCVD = 6;
  localparam int unsigned BIT_MAGIC_RCVD = 5;
  localparam int unsigned BIT_WAKE_FRAME_EN = 2;
  localparam int unsigned BIT_MAGIC_EN = 1;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // ==========================================================================
  // Frame layout and length limits
  // ==========================================================================
  localparam int unsigned LEN_W = 12;
  localparam logic [LEN_W-1:0] TAG_HI_POS = 12'h00c;
  localparam logic [LEN_W-1:0] TAG_LO_POS = 12'h00d;
  localparam logic [LEN_W-1:0] LEN_PLAIN_MAX = 12'd1518;
  localparam logic [LEN_W-1:0] LEN_FIRST_TAG_MAX = 12'd1522;
  localparam logic [LEN_W-1:0] LEN_SECOND_TAG_MAX = 12'd1538;
  localparam logic [LEN_W-1:0] LEN_SATURATE = 12'hfff;
  localparam int unsigned FILTER_ENTRIES = 8;

  // ==========================================================================
  // Bus answer states
  // ==========================================================================
  typedef enum logic [0:0] {
    HMVWF_BUS_IDLE = 1'b0,
    HMVWF_BUS_DONE = 1'b1
  } hmvwf_bus_e;

endpackage : hmvwf_pkg

// File: core/hmvwf_top.sv
// Tag recognition, frame length limits and wake-up filter with APB registers.
// Summary of operation
// - The first tag identifier is compared with frame bytes 13 and 14 and a match raises the limit to 1522 bytes.
// - The second tag identifier is compared with frame bytes 13 and 14 and a match raises the limit to 1538 bytes.
// - Both identifiers look at bytes 13 and 14 and come out of reset as all ones.
// - When both identifiers match the same frame the first one wins and the limit is 1522 bytes.
// - Each write to the filter port fills the entry under an internal pointer, starting at zero, then advances it.
// - After eight entries the pointer wraps to entry zero and writes repeat in the same order.
// - Any reset returns the filter pointer to zero and the filter port cannot be read.
// - With the global unicast enable at bit 9 set, a received global unicast counts as a wake-up frame.
// - A frame is a global unicast when bit 0 of its destination address is zero.
// - A valid wake-up frame sets the flag at bit 6, which holds until software writes one to it.
// - A valid magic packet sets the flag at bit 5, which holds until software writes one to it.
// - Wake-up frames from the pattern matcher are detected only while the enable at bit 2 is set; a global unicast needs only bit 9.
// - Magic packets are recognised only while the enable at bit 1 is set.
//
// The APB interface to the registers was chosen for this implementation.
module hmvwf_top #(
  parameter int unsigned FILTER_DEPTH = hmvwf_pkg::FILTER_ENTRIES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic soft_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hmvwf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic wake_pattern_hit,
  input wire logic magic_packet_hit,
  output logic frame_done,
  output logic frame_first_tag,
  output logic frame_second_tag,
  output logic frame_length_ok,
  output logic [hmvwf_pkg::LEN_W-1:0] frame_length_limit,
  output logic [FILTER_DEPTH*32-1:0] wake_filter_table,
  output logic wake_frame_enable,
  output logic magic_packet_enable,
  output logic wake_event,
  output logic irq
);
  import hmvwf_pkg::*;

  localparam int unsigned PTR_W = (FILTER_DEPTH > 1) ? $clog2(FILTER_DEPTH) : 1;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // The pointer wraps by natural overflow, so the depth must be a power of two.
  if (FILTER_DEPTH < 2 || (FILTER_DEPTH & (FILTER_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("hmvwf_top: FILTER_DEPTH must be a power of two of at least 2");
  end

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [TAG_W-1:0] first_tag_id_field;
  logic [TAG_W-1:0] second_tag_id_field;
  logic global_unicast_wake_enable;
  logic wake_frame_received_flag;
  logic magic_packet_received_flag;
  logic wake_frame_en;
  logic magic_en;
  logic mask_wake_frame;
  logic mask_magic;
  logic [PTR_W-1:0] filter_ptr;
  logic [31:0] wake_filter_word [FILTER_DEPTH];
  hmvwf_bus_e bus_state;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  // One wait state: the answer is registered in the first access cycle and
  // presented with pready in the second, so every bus output is a flip-flop.
  logic access_end;
  logic wr_commit;
  logic addr_hit;
  logic [31:0] read_value;
  logic [31:0] wake_ctrl_view;
  logic [31:0] mask_view;

  assign access_end = psel & penable & pready;
  assign wr_commit = access_end & pwrite;

  always_comb begin
    wake_ctrl_view = DATA_ZERO;
    wake_ctrl_view[BIT_GLOBAL_UNICAST_EN] = global_unicast_wake_enable;
    wake_ctrl_view[BIT_WAKE_FRAME_RCVD] = wake_frame_received_flag;
    wake_ctrl_view[BIT_MAGIC_RCVD] = magic_packet_received_flag;
    wake_ctrl_view[BIT_WAKE_FRAME_EN] = wake_frame_en;
    wake_ctrl_view[BIT_MAGIC_EN] = magic_en;
    mask_view = DATA_ZERO;
    mask_view[BIT_WAKE_FRAME_RCVD] = mask_wake_frame;
    mask_view[BIT_MAGIC_RCVD] = mask_magic;
  end

  always_comb begin
    addr_hit = 1'b1;
    read_value = DATA_ZERO;
    case (paddr)
      ADDR_FIRST_TAG: begin
        read_value[TAG_W-1:0] = first_tag_id_field;
      end
      ADDR_SECOND_TAG: begin
        read_value[TAG_W-1:0] = second_tag_id_field;
      end
      ADDR_WAKE_FILTER: begin
        read_value = DATA_ZERO;
      end
      ADDR_WAKE_CTRL: begin
        read_value = wake_ctrl_view;
      end
      ADDR_IRQ_MASK: begin
        read_value = mask_view;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_state <= HMVWF_BUS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= DATA_ZERO;
    end else begin
      case (bus_state)
        HMVWF_BUS_IDLE: begin
          if (psel && penable) begin
            bus_state <= HMVWF_BUS_DONE;
            pready <= 1'b1;
            pslverr <= ~addr_hit;
            prdata <= pwrite ? DATA_ZERO : read_value;
          end
        end
        HMVWF_BUS_DONE: begin
          bus_state <= HMVWF_BUS_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= DATA_ZERO;
        end
        default: begin
          bus_state <= HMVWF_BUS_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= DATA_ZERO;
        end
      endcase
    end
  end

  // ==========================================================================
  // Tag identifier registers
  // ==========================================================================
  // Byte strobes are honoured on the two low lanes; the upper half is reserved.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      first_tag_id_field <= TAG_RESET;
      second_tag_id_field <= TAG_RESET;
    end else if (wr_commit) begin
      if (paddr == ADDR_FIRST_TAG) begin
        if (pstrb[0]) first_tag_id_field[7:0] <= pwdata[7:0];
        if (pstrb[1]) first_tag_id_field[15:8] <= pwdata[15:8];
      end
      if (paddr == ADDR_SECOND_TAG) begin
        if (pstrb[0]) second_tag_id_field[7:0] <= pwdata[7:0];
        if (pstrb[1]) second_tag_id_field[15:8] <= pwdata[15:8];
      end
    end
  end

  // ==========================================================================
  // Wake-up filter table
  // ==========================================================================
  // Filter words are written whole; the strobes do not apply, since a partial
  // write would still move the pointer and leave the table out of step.
  logic filter_write;
  assign filter_write = wr_commit & (paddr == ADDR_WAKE_FILTER);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      filter_ptr <= '0;
    end else if (soft_reset) begin
      filter_ptr <= '0;
    end else if (filter_write) begin
      filter_ptr <= filter_ptr + PTR_W'(1);
    end
  end

  for (genvar i = 0; i < FILTER_DEPTH; i++) begin : g_filter
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        wake_filter_word[i] <= DATA_ZERO;
      end else if (filter_write && filter_ptr == PTR_W'(i)) begin
        wake_filter_word[i] <= pwdata;
      end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        wake_filter_table[i*32 +: 32] <= DATA_ZERO;
      end else begin
        wake_filter_table[i*32 +: 32] <= wake_filter_word[i];
      end
    end
  end

  // ==========================================================================
  // Frame tracking
  // ==========================================================================
  logic [LEN_W-1:0] byte_count;
  logic [7:0] tag_hi;
  logic hit_first;
  logic hit_second;
  logic unicast;
  logic [LEN_W-1:0] next_length;
  logic [15:0] tag_word;
  logic [LEN_W-1:0] limit_now;
  logic hit_first_now;
  logic hit_second_now;

  assign next_length = (byte_count == LEN_SATURATE) ? LEN_SATURATE : byte_count + LEN_W'(1);
  assign tag_word = {tag_hi, rx_data};
  assign hit_first_now = (byte_count == TAG_LO_POS) ? (tag_word == first_tag_id_field) : hit_first;
  assign hit_second_now = (byte_count == TAG_LO_POS) ? (tag_word == second_tag_id_field) : hit_second;

  assign limit_now = hit_first_now ? LEN_FIRST_TAG_MAX :
                     hit_second_now ? LEN_SECOND_TAG_MAX : LEN_PLAIN_MAX;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      byte_count <= '0;
      tag_hi <= 8'h00;
      hit_first <= 1'b0;
      hit_second <= 1'b0;
      unicast <= 1'b0;
    end else if (rx_valid) begin
      byte_count <= rx_last ? '0 : next_length;
      if (byte_count == '0) begin
        unicast <= ~rx_data[0];
      end
      // Bytes 13 and 14 are compared.
      if (byte_count == TAG_HI_POS) begin
        tag_hi <= rx_data;
      end
      if (rx_last) begin
        hit_first <= 1'b0;
        hit_second <= 1'b0;
      end else begin
        hit_first <= hit_first_now;
        hit_second <= hit_second_now;
      end
    end
  end

  logic frame_end;
  assign frame_end = rx_valid & rx_last;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      frame_done <= 1'b0;
      frame_first_tag <= 1'b0;
      frame_second_tag <= 1'b0;
      frame_length_ok <= 1'b0;
      frame_length_limit <= LEN_PLAIN_MAX;
    end else begin
      frame_done <= frame_end;
      if (frame_end) begin
        frame_first_tag <= hit_first_now;
        frame_second_tag <= hit_second_now & ~hit_first_now;
        frame_length_limit <= limit_now;
        frame_length_ok <= (next_length <= limit_now);
      end
    end
  end

  // ==========================================================================
  // Wake control and status
  // ==========================================================================
  logic unicast_wake;
  logic set_wake_frame;
  logic set_magic;
  logic clr_wake_frame;
  logic clr_magic;
  logic ctrl_write;
  logic mask_write;

  assign ctrl_write = wr_commit & (paddr == ADDR_WAKE_CTRL);
  assign mask_write = wr_commit & (paddr == ADDR_IRQ_MASK);
  // Global unicast qualifies as wake frame.
  assign unicast_wake = global_unicast_wake_enable & frame_end & unicast & (byte_count != '0);
  assign set_wake_frame = (wake_frame_en & wake_pattern_hit) | unicast_wake;
  assign set_magic = magic_en & magic_packet_hit;
  assign clr_wake_frame = ctrl_write & pstrb[0] & pwdata[BIT_WAKE_FRAME_RCVD];
  assign clr_magic = ctrl_write & pstrb[0] & pwdata[BIT_MAGIC_RCVD];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      global_unicast_wake_enable <= 1'b0;
      wake_frame_en <= 1'b0;
      magic_en <= 1'b0;
    end else if (ctrl_write) begin
      if (pstrb[1]) global_unicast_wake_enable <= pwdata[BIT_GLOBAL_UNICAST_EN];
      if (pstrb[0]) wake_frame_en <= pwdata[BIT_WAKE_FRAME_EN];
      if (pstrb[0]) magic_en <= pwdata[BIT_MAGIC_EN];
    end
  end

  // Set wins over a clear landing in the same cycle, so no event is lost.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wake_frame_received_flag <= 1'b0;
      magic_packet_received_flag <= 1'b0;
    end else begin
      if (set_wake_frame) wake_frame_received_flag <= 1'b1;
      else if (clr_wake_frame) wake_frame_received_flag <= 1'b0;
      if (set_magic) magic_packet_received_flag <= 1'b1;
      else if (clr_magic) magic_packet_received_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mask_wake_frame <= 1'b0;
      mask_magic <= 1'b0;
    end else if (mask_write && pstrb[0]) begin
      mask_wake_frame <= pwdata[BIT_WAKE_FRAME_RCVD];
      mask_magic <= pwdata[BIT_MAGIC_RCVD];
    end
  end

  // ==========================================================================
  // Outputs toward power management and the host
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wake_event <= 1'b0;
      irq <= 1'b0;
      wake_frame_enable <= 1'b0;
      magic_packet_enable <= 1'b0;
    end else begin
      wake_event <= set_wake_frame | set_magic;
      irq <= (wake_frame_received_flag & mask_wake_frame) | (magic_packet_received_flag & mask_magic);
      wake_frame_enable <= wake_frame_en;
      magic_packet_enable <= magic_en;
    end
  end

endmodule : hmvwf_top

// File: verif/hmvwf_fabric_model.sv
// Switch fabric stand-in delivering frame bytes and matcher pulses.
module hmvwf_fabric_model (
  input wire logic clk_sys,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic wake_pattern_hit,
  output logic magic_packet_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {rx_valid, rx_last, wake_pattern_hit, magic_packet_hit} = 4'h0;
    rx_data = 8'h00;
  end
  // Idle data shows the inverse of the last byte so a stale value never looks valid.
  // In slow mode the idle gap comes before every byte but the first, so the last byte is never trailed by a gap.
  task automatic send(input logic [15:0] tag, input logic [7:0] da0, input int len, input bit slow);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < len; i++) begin
      if (slow && i > 0) begin
        rx_valid <= 1'b0;
        rx_data <= ~b;
        @(posedge clk_sys);
      end
      b = (i == 0) ? da0 : (i == 12) ? tag[15:8] : (i == 13) ? tag[7:0] : 8'(i);
      rx_valid <= 1'b1;
      rx_data <= b;
      rx_last <= (i == len - 1);
      @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~b;
  endtask : send
  task automatic hit(input bit magic);
    magic_packet_hit <= magic;
    wake_pattern_hit <= !magic;
    @(posedge clk_sys);
    magic_packet_hit <= 1'b0;
    wake_pattern_hit <= 1'b0;
  endtask : hit
endmodule : hmvwf_fabric_model

// File: verif/hmvwf_monitor.sv
// Port checker for the tag and wake-up filter block.
module hmvwf_monitor
  import hmvwf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic magic_packet_hit,
  input wire logic magic_packet_enable,
  input wire logic frame_done,
  input wire logic frame_first_tag,
  input wire logic frame_second_tag,
  input wire logic [hmvwf_pkg::LEN_W-1:0] frame_length_limit,
  input wire logic wake_event
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Register bus
  // ==========================================================================
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_no_data: assert property (pslverr |-> pready && prdata == DATA_ZERO)
    else $error("pslverr without pready or with data");
  // ==========================================================================
  // Frame results
  // ==========================================================================
  a_done_after_last: assert property (rx_valid && rx_last |=> frame_done)
    else $error("frame_done missing after last byte");
  a_first_limit: assert property (frame_done && frame_first_tag |-> frame_length_limit == LEN_FIRST_TAG_MAX)
    else $error("first tag limit wrong");
  a_second_limit: assert property (frame_done && frame_second_tag |-> !frame_first_tag
    && frame_length_limit == LEN_SECOND_TAG_MAX)
    else $error("second tag limit wrong");
  a_plain_limit: assert property (frame_done && !frame_first_tag && !frame_second_tag
    |-> frame_length_limit == LEN_PLAIN_MAX)
    else $error("plain limit wrong");
  a_result_hold: assert property ($changed(frame_length_limit) |-> frame_done)
    else $error("limit changed outside frame end");
  a_magic_wake: assert property (magic_packet_hit && magic_packet_enable |-> ##[1:3] wake_event)
    else $error("no wake event after magic packet");
endmodule : hmvwf_monitor

bind hmvwf_top hmvwf_monitor u_mon (.clk_sys, .rst_b, .psel, .penable, .prdata, .pready, .pslverr, .rx_valid,
  .rx_last, .magic_packet_hit, .magic_packet_enable, .frame_done, .frame_first_tag, .frame_second_tag,
  .frame_length_limit, .wake_event);

// File: verif/hmvwf_top_tb.sv
// Self-checking testbench for the tag and wake-up filter block.
module hmvwf_top_tb;
  import hmvwf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_b, soft_reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic rx_valid, rx_last, wake_pattern_hit, magic_packet_hit, frame_done, frame_first_tag, frame_second_tag;
  logic [7:0] rx_data;
  logic [LEN_W-1:0] frame_length_limit;
  logic [255:0] tbl;
  logic frame_length_ok, wake_frame_enable, magic_packet_enable, wake_event, irq, e;
  int num_errors, num_checks;
  hmvwf_top dut (.clk_sys, .rst_b, .soft_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .rx_valid, .rx_data, .rx_last, .wake_pattern_hit, .magic_packet_hit, .frame_done,
    .frame_first_tag, .frame_second_tag, .frame_length_ok, .frame_length_limit, .wake_filter_table(tbl),
    .wake_frame_enable, .magic_packet_enable, .wake_event, .irq);
  hmvwf_fabric_model fab (.clk_sys, .rx_valid, .rx_data, .rx_last, .wake_pattern_hit, .magic_packet_hit);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // Called just after a rising edge; holds the request until pready is sampled.
  // One idle edge follows, so a second call never drives psel twice in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, DATA_ZERO);
    chk(q, exp);
  endtask : rd
  task automatic frame(input logic [15:0] tag, input logic [7:0] da0, input int len, input bit slow,
    input logic [1:0] tags, input logic [LEN_W-1:0] lim, input logic ok);
    fab.send(tag, da0, len, slow);
    @(posedge clk_sys);
    chk(frame_done, 1'b1);
    chk({frame_first_tag, frame_second_tag, frame_length_ok, frame_length_limit}, {tags, ok, lim});
  endtask : frame
  task automatic ev(input logic exp);
    logic s;
    s = 1'b0;
    repeat (4) begin
      @(posedge clk_sys);
      s = s | wake_event;
    end
    chk(s, exp);
  endtask : ev
  task automatic t_reset;
    rd(ADDR_FIRST_TAG, 32'h0000_ffff);
    rd(ADDR_SECOND_TAG, 32'h0000_ffff);
    rd(ADDR_WAKE_CTRL, DATA_ZERO);
    rd(ADDR_WAKE_FILTER, DATA_ZERO);
    apb(1'b0, 8'h3c, DATA_ZERO);
    chk(e, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_tags;
    apb(1'b1, ADDR_FIRST_TAG, 32'h0000_8100);
    apb(1'b1, ADDR_SECOND_TAG, 32'h0000_88a8);
    frame(16'h8100, 8'h00, 1522, 1'b0, 2'b10, LEN_FIRST_TAG_MAX, 1'b1);
    frame(16'h8100, 8'h00, 1523, 1'b0, 2'b10, LEN_FIRST_TAG_MAX, 1'b0);
    frame(16'h88a8, 8'h00, 1538, 1'b1, 2'b01, LEN_SECOND_TAG_MAX, 1'b1);
    frame(16'h0800, 8'h00, 1519, 1'b0, 2'b00, LEN_PLAIN_MAX, 1'b0);
    apb(1'b1, ADDR_SECOND_TAG, 32'h0000_8100);
    frame(16'h8100, 8'h00, 1530, 1'b0, 2'b10, LEN_FIRST_TAG_MAX, 1'b0);
    $display("test tags done");
  endtask : t_tags
  task automatic t_filter;
    for (int i = 0; i < 9; i++) apb(1'b1, ADDR_WAKE_FILTER, 32'h1000_0000 + i);
    repeat (2) @(posedge clk_sys);
    chk(tbl[31:0], 32'h1000_0008);
    for (int i = 1; i < 8; i++) chk(tbl[i*32+:32], 32'h1000_0000 + i);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    apb(1'b1, ADDR_WAKE_FILTER, 32'h2000_0000);
    repeat (2) @(posedge clk_sys);
    chk(tbl[63:0], {32'h1000_0001, 32'h2000_0000});
    $display("test filter done");
  endtask : t_filter
  task automatic t_wake;
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0020);
    apb(1'b1, ADDR_WAKE_CTRL, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    chk({wake_frame_enable, magic_packet_enable}, 2'b01);
    fab.hit(1'b1);
    ev(1'b1);
    rd(ADDR_WAKE_CTRL, 32'h0000_0022);
    chk(irq, 1'b1);
    apb(1'b1, ADDR_WAKE_CTRL, 32'h0000_0020);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    fab.hit(1'b1);
    ev(1'b0);
    rd(ADDR_WAKE_CTRL, DATA_ZERO);
    apb(1'b1, ADDR_WAKE_CTRL, 32'h0000_0004);
    repeat (2) @(posedge clk_sys);
    chk({wake_frame_enable, magic_packet_enable}, 2'b10);
    fab.hit(1'b0);
    ev(1'b1);
    rd(ADDR_WAKE_CTRL, 32'h0000_0044);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_WAKE_CTRL, 32'h0000_0040);
    repeat (2) @(posedge clk_sys);
    fab.hit(1'b0);
    ev(1'b0);
    rd(ADDR_WAKE_CTRL, DATA_ZERO);
    apb(1'b1, ADDR_WAKE_CTRL, 32'h0000_0200);
    frame(16'h0800, 8'h01, 20, 1'b0, 2'b00, LEN_PLAIN_MAX, 1'b1);
    rd(ADDR_WAKE_CTRL, 32'h0000_0200);
    frame(16'h0800, 8'h02, 20, 1'b0, 2'b00, LEN_PLAIN_MAX, 1'b1);
    rd(ADDR_WAKE_CTRL, 32'h0000_0240);
    $display("test wake done");
  endtask : t_wake
  initial begin
    {rst_b, soft_reset, psel, penable, pwrite} = 5'h00;
    paddr = 8'h00;
    pwdata = DATA_ZERO;
    pstrb = 4'hf;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_tags();
    t_filter();
    t_wake();
    results();
  end
  // A run of about 9400 cycles is expected; the limit leaves ample margin.
  initial begin
    #150us;
    num_errors++;
    results();
  end
endmodule : hmvwf_top_tb
